/* File: core/pcd_consts.vh */
// Constants for the clock divider and fanout block
`ifndef PCD_CONSTS_VH
`define PCD_CONSTS_VH

// Register byte addresses
`define PCD_ADDR_CTRL      12'h000
`define PCD_ADDR_STATUS    12'h004

// Register decode results
`define PCD_DEC_NONE       2'h0
`define PCD_DEC_CTRL       2'h1
`define PCD_DEC_STATUS     2'h2

// Control register layout
`define PCD_CTRL_W         10
`define PCD_CTRL_RESET     10'h002
`define PCD_CTRL_REF_SEL   0
`define PCD_CTRL_PLL_EN    1
`define PCD_CTRL_OE_N      2
`define PCD_CTRL_FSEL_A    3
`define PCD_CTRL_FSEL_B    4
`define PCD_CTRL_FSEL_C    5
`define PCD_CTRL_FSEL_D    6
`define PCD_CTRL_FB_LO     8
`define PCD_CTRL_FB_HI     9

// Feedback bank codes
`define PCD_FB_BANK_A      2'h0
`define PCD_FB_BANK_B      2'h1
`define PCD_FB_BANK_C      2'h2
`define PCD_FB_BANK_D      2'h3

// Status register layout
`define PCD_STAT_LOCK      0
`define PCD_STAT_BYPASS    1
`define PCD_STAT_REF_SEEN  2
`define PCD_STAT_LOOP_OPEN 3
`define PCD_STAT_PER_LO    16

// Divide ratios of the banks
`define PCD_DIV_A_LO       4'h2
`define PCD_DIV_A_HI       4'h4
`define PCD_DIV_BCD_LO     4'h4
`define PCD_DIV_BCD_HI     4'h8

// Oscillator multiplier while the loop is open (lowest frequency)
`define PCD_MULT_OPEN      4'h1

// Outputs per bank
`define PCD_FAN_A          1
`define PCD_FAN_B          1
`define PCD_FAN_C          2
`define PCD_FAN_D          5

// Reference periods with feedback seen before lock is declared
`define PCD_LOCK_PERIODS   4

`endif

/* File: core/pcd_sync3.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pcd_sync3 #(
  parameter W = 1
) (
  input  wire         clk_in,   // System clock
  input  wire         rst_n_in, // Asynchronous reset, active low
  input  wire         ce_in,    // Clock enable
  input  wire [W-1:0] pin_in,   // Asynchronous pin levels
  output wire [W-1:0] lvl_out   // Filtered synchronous levels
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;

  genvar i;

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end
    else if (ce_in)
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Each bit only moves when stages two and three agree
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          lvl_q[i] <= 1'b0;
        else if (ce_in && (s2_q[i] == s3_q[i]))
          lvl_q[i] <= s3_q[i];
      end
    end
  endgenerate

  assign lvl_out = lvl_q;

endmodule // pcd_sync3

/* File: core/pcd_bank_div.v */
// One output bank: edge-counting divider with fanout
`timescale 1ns/1ps
module pcd_bank_div #(
  parameter [3:0] DIV_LO = 4'h4,
  parameter [3:0] DIV_HI = 4'h8,
  parameter       FANOUT = 1
) (
  input  wire              clk_in,   // System clock
  input  wire              rst_n_in, // Asynchronous reset, active low
  input  wire              ce_in,    // Clock enable
  input  wire              tick_in,  // One rising edge of the source clock
  input  wire              sel_in,   // Divide select, 0 low ratio, 1 high ratio
  input  wire              en_in,    // Outputs enabled
  output wire [FANOUT-1:0] outs_out  // Divided clock, one copy per output
);

  reg  [2:0]        cnt_q;
  reg  [FANOUT-1:0] out_q;
  wire [3:0]        ratio;
  wire [2:0]        half_m1;

  assign ratio   = sel_in ? DIV_HI : DIV_LO;
  assign half_m1 = ratio[3:1] - 3'h1;

  // Counts source edges only, so it holds at any rate down to DC
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 3'h0;
      out_q <= {FANOUT{1'b0}};
    end
    else if (ce_in)
    begin
      if (!en_in)
      begin
        cnt_q <= 3'h0;
        out_q <= {FANOUT{1'b0}};
      end
      else if (tick_in)
      begin
        // A select change mid-count toggles at once instead of overrunning
        if (cnt_q >= half_m1)
        begin
          cnt_q <= 3'h0;
          out_q <= ~out_q;
        end
        else
          cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  assign outs_out = out_q;

endmodule // pcd_bank_div

/* File: core/pcd_clock_fanout.v */
// Clock driver: reference select, oscillator model, bank dividers, APB registers
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "pcd_consts.vh"

// How it works
// - Reference select 0 takes the differential input, 1 the single-ended one.
// - PLL enable low bypasses the oscillator; reference edges drive the dividers.
// - PLL enable high drives the dividers from the oscillator.
// - Output enable high disables outputs, opens loop, oscillator at minimum, lock lost.
// - Output enable low enables outputs; with PLL enable high it also closes loop, lock returns.
// - Bank A divides by 2 or 4; banks B, C, D by 4 or 8.
// - Oscillator runs at two, four or eight times reference, per feedback bank ratio (A: 2 or 4).
// - Bypass mode is fully static, working down to a stopped reference.
// - Nine outputs: one in A, one in B, two in C, five in D.
module pcd_clock_fanout #(
  parameter ADDR_W       = 12,
  parameter PER_W        = 16,
  parameter LOCK_PERIODS = `PCD_LOCK_PERIODS
) (
  input  wire              ref_clk_in,        // System clock, 40 MHz
  input  wire              rst_n_in,          // Asynchronous reset, active low
  input  wire              ce_in,             // Clock enable, freezes all state when low
  input  wire              psel_in,           // APB select
  input  wire              penable_in,        // APB enable
  input  wire              pwrite_in,         // APB direction, 1 write
  input  wire [ADDR_W-1:0] paddr_in,          // APB byte address
  input  wire [31:0]       pwdata_in,         // APB write data
  output wire [31:0]       prdata_out,        // APB read data
  output wire              pready_out,        // APB ready
  output wire              pslverr_out,       // APB error on unmapped address
  input  wire              diff_ref_p_in,     // Differential reference, true leg
  input  wire              diff_ref_n_in,     // Differential reference, complement leg
  input  wire              single_ref_clk_in, // Single-ended reference clock
  input  wire              feedback_in,       // External feedback from one bank output
  output wire              bank_a_out,        // Bank A clock
  output wire              bank_b_out,        // Bank B clock
  output wire [1:0]        bank_c_outs,       // Bank C clocks
  output wire [4:0]        bank_d_outs,       // Bank D clocks
  output wire              lock_out           // Loop locked
);

  // Register decode shared by the read, write and error paths
  function [1:0] reg_decode;
    input [ADDR_W-1:0] addr;
    begin
      if (addr == `PCD_ADDR_CTRL)
        reg_decode = `PCD_DEC_CTRL;
      else if (addr == `PCD_ADDR_STATUS)
        reg_decode = `PCD_DEC_STATUS;
      else
        reg_decode = `PCD_DEC_NONE;
    end
  endfunction

  // Divide ratio of a bank at its current select
  function [3:0] bank_ratio;
    input [1:0] bank;
    input [3:0] fsel;
    begin
      case (bank)
        `PCD_FB_BANK_A: bank_ratio = fsel[0] ? `PCD_DIV_A_HI : `PCD_DIV_A_LO;
        `PCD_FB_BANK_B: bank_ratio = fsel[1] ? `PCD_DIV_BCD_HI : `PCD_DIV_BCD_LO;
        `PCD_FB_BANK_C: bank_ratio = fsel[2] ? `PCD_DIV_BCD_HI : `PCD_DIV_BCD_LO;
        default:        bank_ratio = fsel[3] ? `PCD_DIV_BCD_HI : `PCD_DIV_BCD_LO;
      endcase
    end
  endfunction

  reg  [`PCD_CTRL_W-1:0] ctrl_q;
  reg  [31:0]            prdata_q;
  reg                    ref_lvl_q;
  reg                    fb_lvl_q;
  reg  [PER_W-1:0]       per_cnt_q;
  reg  [PER_W-1:0]       per_q;
  reg  [PER_W-1:0]       acc_q;
  reg                    fb_seen_q;
  reg  [7:0]             lock_cnt_q;
  reg                    lock_q;

  wire [3:0]             pin_lvl;
  wire                   diff_lvl;
  wire                   ref_lvl;
  wire                   ref_rise;
  wire                   fb_rise;
  wire                   ref_sel;
  wire                   pll_en;
  wire                   oe_n;
  wire [3:0]             fsel;
  wire [1:0]             fb_bank;
  wire                   loop_closed;
  wire [3:0]             mult;
  wire [PER_W:0]         acc_sum;
  wire [PER_W:0]         acc_wrap;
  wire                   acc_over;
  wire                   osc_tick;
  wire                   div_tick;
  wire                   outs_en;
  wire [1:0]             dec;
  wire                   apb_setup;
  wire                   apb_access;
  wire [31:0]            status_word;

  assign ref_sel = ctrl_q[`PCD_CTRL_REF_SEL];
  assign pll_en  = ctrl_q[`PCD_CTRL_PLL_EN];
  assign oe_n    = ctrl_q[`PCD_CTRL_OE_N];
  assign fsel    = ctrl_q[`PCD_CTRL_FSEL_D:`PCD_CTRL_FSEL_A];
  assign fb_bank = ctrl_q[`PCD_CTRL_FB_HI:`PCD_CTRL_FB_LO];

  // APB slave; an access completes in its first access cycle with ce_in high
  assign dec        = reg_decode(paddr_in);
  assign apb_setup  = psel_in & ~penable_in;
  assign apb_access = psel_in & penable_in & ce_in;
  assign pready_out = ce_in;
  assign pslverr_out = psel_in & penable_in & (dec == `PCD_DEC_NONE);
  assign prdata_out = prdata_q;

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_q   <= `PCD_CTRL_RESET;
      prdata_q <= 32'h00000000;
    end
    else if (ce_in)
    begin
      if (apb_access && pwrite_in && (dec == `PCD_DEC_CTRL))
        ctrl_q <= pwdata_in[`PCD_CTRL_W-1:0];
      // Read data is captured in the setup cycle so it comes from a flop
      if (apb_setup && !pwrite_in)
      begin
        case (dec)
          `PCD_DEC_CTRL:   prdata_q <= {{(32-`PCD_CTRL_W){1'b0}}, ctrl_q};
          `PCD_DEC_STATUS: prdata_q <= status_word;
          default:         prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Pin inputs come from other clocks and cross through three stages
  pcd_sync3 #(
    .W (4)
  ) u_sync (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .pin_in   ({feedback_in, single_ref_clk_in, diff_ref_n_in, diff_ref_p_in}),
    .lvl_out  (pin_lvl)
  );

  assign diff_lvl = pin_lvl[0] & ~pin_lvl[1];
  assign ref_lvl  = ref_sel ? pin_lvl[2] : diff_lvl;

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ref_lvl_q <= 1'b0;
      fb_lvl_q  <= 1'b0;
    end
    else if (ce_in)
    begin
      ref_lvl_q <= ref_lvl;
      fb_lvl_q  <= pin_lvl[3];
    end
  end

  assign ref_rise = ref_lvl & ~ref_lvl_q;
  assign fb_rise  = pin_lvl[3] & ~fb_lvl_q;

  // Loop is closed only with the oscillator in use and outputs on
  assign loop_closed = pll_en & ~oe_n;
  // Feedback bank ratio sets the multiplier; open loop falls to minimum
  assign mult = loop_closed ? bank_ratio(fb_bank, fsel) : `PCD_MULT_OPEN;

  // Reference period in system cycles, saturating for a stopped reference
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      per_cnt_q <= {PER_W{1'b0}};
      per_q     <= {PER_W{1'b0}};
    end
    else if (ce_in)
    begin
      if (ref_rise)
      begin
        per_q     <= per_cnt_q;
        per_cnt_q <= {{(PER_W-1){1'b0}}, 1'b1};
      end
      else if (per_cnt_q != {PER_W{1'b1}})
        per_cnt_q <= per_cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // Oscillator model: mult ticks per reference period, realigned on each edge
  assign acc_sum  = {1'b0, acc_q} + {{(PER_W-3){1'b0}}, mult};
  assign acc_over = (per_q != {PER_W{1'b0}}) && (acc_sum >= {1'b0, per_q});
  assign acc_wrap = acc_sum - {1'b0, per_q};
  assign osc_tick = ref_rise | acc_over;

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      acc_q <= {PER_W{1'b0}};
    else if (ce_in)
    begin
      if (ref_rise)
        acc_q <= {PER_W{1'b0}};
      else if (acc_over)
        acc_q <= acc_wrap[PER_W-1:0];
      else if (per_q != {PER_W{1'b0}})
        acc_q <= acc_sum[PER_W-1:0];
    end
  end

  // Bypass counts reference edges directly, so no minimum rate applies
  assign div_tick = pll_en ? osc_tick : ref_rise;
  assign outs_en  = ~oe_n;

  // Lock needs feedback edges in consecutive reference periods
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fb_seen_q  <= 1'b0;
      lock_cnt_q <= 8'h00;
      lock_q     <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!loop_closed)
      begin
        fb_seen_q  <= 1'b0;
        lock_cnt_q <= 8'h00;
        lock_q     <= 1'b0;
      end
      else if (ref_rise)
      begin
        // A feedback edge in the same cycle starts the next period's credit
        fb_seen_q <= fb_rise;
        if (fb_seen_q)
        begin
          if (lock_cnt_q >= LOCK_PERIODS[7:0] - 8'h01)
            lock_q <= 1'b1;
          else
            lock_cnt_q <= lock_cnt_q + 8'h01;
        end
        else
        begin
          lock_cnt_q <= 8'h00;
          lock_q     <= 1'b0;
        end
      end
      else if (fb_rise)
        fb_seen_q <= 1'b1;
    end
  end

  assign lock_out = lock_q;

  assign status_word = {per_q,
                        {(`PCD_STAT_PER_LO-`PCD_STAT_LOOP_OPEN-1){1'b0}},
                        ~loop_closed,
                        per_q != {PER_W{1'b0}},
                        ~pll_en,
                        lock_q};

  // Four banks, nine outputs in all
  pcd_bank_div #(
    .DIV_LO (`PCD_DIV_A_LO),
    .DIV_HI (`PCD_DIV_A_HI),
    .FANOUT (`PCD_FAN_A)
  ) u_bank_a (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .tick_in  (div_tick),
    .sel_in   (fsel[0]),
    .en_in    (outs_en),
    .outs_out (bank_a_out)
  );

  pcd_bank_div #(
    .DIV_LO (`PCD_DIV_BCD_LO),
    .DIV_HI (`PCD_DIV_BCD_HI),
    .FANOUT (`PCD_FAN_B)
  ) u_bank_b (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .tick_in  (div_tick),
    .sel_in   (fsel[1]),
    .en_in    (outs_en),
    .outs_out (bank_b_out)
  );

  pcd_bank_div #(
    .DIV_LO (`PCD_DIV_BCD_LO),
    .DIV_HI (`PCD_DIV_BCD_HI),
    .FANOUT (`PCD_FAN_C)
  ) u_bank_c (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .tick_in  (div_tick),
    .sel_in   (fsel[2]),
    .en_in    (outs_en),
    .outs_out (bank_c_outs)
  );

  pcd_bank_div #(
    .DIV_LO (`PCD_DIV_BCD_LO),
    .DIV_HI (`PCD_DIV_BCD_HI),
    .FANOUT (`PCD_FAN_D)
  ) u_bank_d (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .tick_in  (div_tick),
    .sel_in   (fsel[3]),
    .en_in    (outs_en),
    .outs_out (bank_d_outs)
  );

endmodule // pcd_clock_fanout

/* File: sim/pcd_board_src.sv */
// Board clock source model: two references and the feedback wiring
`timescale 1ns/1ps
module pcd_board_src (
  input  wire         clk_in,    // Bench clock
  input  wire  [15:0] per_d_in,  // Differential period in cycles, even
  input  wire  [15:0] per_s_in,  // Single-ended period in cycles, even
  input  wire  [1:0]  fb_sel_in, // Bank wired back
  input  wire  [3:0]  taps_in,   // One output per bank, A in bit 0
  output logic        p_out,     // Differential true leg
  output wire         n_out,     // Differential complement leg
  output logic        s_out,     // Single-ended reference
  output wire         fb_out     // Feedback line
);
  logic [15:0] cd_q;
  logic [15:0] cs_q;

  initial
  begin
    p_out = 1'b0;
    s_out = 1'b0;
    cd_q  = 16'h0;
    cs_q  = 16'h0;
  end

  assign n_out  = ~p_out;
  assign fb_out = taps_in[fb_sel_in];

  // Both sources run free, as board oscillators do
  always @(posedge clk_in)
  begin
    cd_q <= (cd_q + 16'h1 >= per_d_in[15:1]) ? 16'h0 : cd_q + 16'h1;
    cs_q <= (cs_q + 16'h1 >= per_s_in[15:1]) ? 16'h0 : cs_q + 16'h1;
    if (cd_q + 16'h1 >= per_d_in[15:1])
      p_out <= ~p_out;
    if (cs_q + 16'h1 >= per_s_in[15:1])
      s_out <= ~s_out;
  end
endmodule // pcd_board_src

/* File: sim/pcd_clock_fanout_asserts.sv */
// Port-level assertions for the clock divider and fanout block
`timescale 1ns/1ps
module pcd_clock_fanout_chk #(
  parameter ADDR_W = 12
) (
  input wire              ref_clk_in,  // Clock
  input wire              rst_n_in,    // Reset, active low
  input wire              ce_in,       // Clock enable
  input wire              psel_in,     // APB select
  input wire              penable_in,  // APB enable
  input wire              pwrite_in,   // APB direction
  input wire [ADDR_W-1:0] paddr_in,    // APB address
  input wire [31:0]       pwdata_in,   // APB write data
  input wire [31:0]       prdata_out,  // APB read data
  input wire              pready_out,  // APB ready
  input wire              pslverr_out, // APB error
  input wire              bank_a_out,  // Bank A
  input wire              bank_b_out,  // Bank B
  input wire [1:0]        bank_c_outs, // Bank C
  input wire [4:0]        bank_d_outs, // Bank D
  input wire              lock_out     // Lock
);
  logic mapped;
  logic oe_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  assign mapped = (paddr_in == 12'h000) || (paddr_in == 12'h004);

  // Shadow of the disable bit, taken from completed writes
  always @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      oe_q <= 1'b0;
    else if (ce_in && psel_in && penable_in && pwrite_in && paddr_in == 12'h000)
      oe_q <= pwdata_in[2];

  a_pready_ce: assert property (pready_out == ce_in)
    else $error("ready does not follow clock enable");
  a_err_unmapped: assert property (psel_in && penable_in && !mapped |-> pslverr_out)
    else $error("no error on unmapped access");
  a_err_only_bad: assert property (pslverr_out |-> psel_in && penable_in && !mapped)
    else $error("error outside an unmapped access");
  a_zero_unmapped: assert property (psel_in && penable_in && !pwrite_in && !mapped |-> prdata_out == 32'h0)
    else $error("unmapped read data not zero");
  a_bank_c_same: assert property (bank_c_outs == {2{bank_c_outs[0]}})
    else $error("bank C outputs differ");
  a_bank_d_same: assert property (bank_d_outs == {5{bank_d_outs[0]}})
    else $error("bank D outputs differ");
  a_off_outs: assert property (oe_q [*3] |-> {bank_a_out, bank_b_out, bank_c_outs, bank_d_outs} == 9'h000)
    else $error("outputs active while disabled");
  a_open_unlocked: assert property (oe_q [*3] |-> !lock_out)
    else $error("lock while loop open");
  a_lock_closed: assert property ($rose(lock_out) |-> !oe_q && !$past(oe_q))
    else $error("lock rose with loop open");
endmodule // pcd_clock_fanout_chk

bind pcd_clock_fanout pcd_clock_fanout_chk #(.ADDR_W(ADDR_W)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .bank_a_out(bank_a_out), .bank_b_out(bank_b_out), .bank_c_outs(bank_c_outs),
  .bank_d_outs(bank_d_outs), .lock_out(lock_out)
);

/* File: sim/testbench.sv */
// Self-checking bench for the clock divider and fanout block
`timescale 1ns/1ps
module testbench;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        ce_in      = 1'b1;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [11:0] paddr_in   = 12'h000;
  logic [31:0] pwdata_in  = 32'h0;
  logic [15:0] per_d      = 16'h0008;
  logic [15:0] per_s      = 16'h000C;
  logic [1:0]  fb_bank    = 2'h1;
  wire  [31:0] prdata_out;
  wire         pready_out, pslverr_out, ref_p, ref_n, ref_s, fb;
  wire         bank_a_out, bank_b_out, lock_out;
  wire  [1:0]  bank_c_outs;
  wire  [4:0]  bank_d_outs;
  wire  [3:0]  taps = {bank_d_outs[4], bank_c_outs[1], bank_b_out, bank_a_out};
  logic [31:0] exp_q[$];
  logic [31:0] meas_val;
  event        meas_ev;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  integer      seed = 32'h4120;

  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cyc++;

  pcd_clock_fanout #(.LOCK_PERIODS(2)) u_dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .diff_ref_p_in(ref_p), .diff_ref_n_in(ref_n), .single_ref_clk_in(ref_s), .feedback_in(fb),
    .bank_a_out(bank_a_out), .bank_b_out(bank_b_out), .bank_c_outs(bank_c_outs),
    .bank_d_outs(bank_d_outs), .lock_out(lock_out)
  );

  pcd_board_src u_src (
    .clk_in(ref_clk_in), .per_d_in(per_d), .per_s_in(per_s), .fb_sel_in(fb_bank),
    .taps_in(taps), .p_out(ref_p), .n_out(ref_n), .s_out(ref_s), .fb_out(fb)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    begin
      checks_done++;
      if (seen !== expv)
      begin
        failures++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
      end
    end
  endtask

  task automatic take(input logic [31:0] seen);
    begin
      // A result with nothing expected is always a mismatch, even if unknown
      if (exp_q.size() == 0)
        check(32'h0000_0001, 32'h0000_0000);
      else
        check(seen, exp_q.pop_front());
    end
  endtask

  // Result watchers: completed reads and posted measurements
  always @(posedge ref_clk_in)
    if (psel_in && penable_in && pready_out === 1'b1 && pwrite_in === 1'b0)
      take(prdata_out);
  always @(meas_ev) take(meas_val);

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    begin
      if (!wr)
        exp_q.push_back(d);
      psel_in   <= 1'b1;
      pwrite_in <= wr;
      paddr_in  <= a;
      pwdata_in <= wr ? d : $random(seed);
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      @(posedge ref_clk_in);
      while (pready_out !== 1'b1)
        @(posedge ref_clk_in);
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      @(posedge ref_clk_in);
    end
  endtask

  task automatic post(input logic [31:0] expv, input logic [31:0] seen);
    begin
      exp_q.push_back(expv);
      meas_val = seen;
      -> meas_ev;
      @(posedge ref_clk_in);
    end
  endtask

  // First period after a change may be short, so it is skipped
  task automatic measure(input int b, input int expv);
    int t0;
    begin
      @(posedge taps[b]);
      @(posedge taps[b]);
      t0 = cyc;
      @(posedge taps[b]);
      post(32'(expv), 32'(cyc - t0));
    end
  endtask

  function automatic int ratio(input int b, input logic f);
    ratio = (b == 0) ? (f ? 4 : 2) : (f ? 8 : 4);
  endfunction

  task close_out;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial
  begin
    #(60000 * 25);
    failures++;
    close_out;
  end

  initial
  begin : main
    int         i, b, p, m;
    logic [3:0] fs;
    logic       rs;
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    apb(1'b0, 12'h000, 32'h0000_0002);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    apb(1'b1, 12'h00C, 32'h0000_0004);
    apb(1'b0, 12'h000, 32'h0000_0002);
    apb(1'b0, 12'h008, 32'h0000_0000);
    $display("register test done");
    for (i = 0; i < 4; i++)
    begin
      rs = i[0];
      fs = 4'($random(seed));
      p  = (i == 3) ? 200 : 8 + 2 * ($random(seed) & 7);
      per_d <= rs ? 16'(p + 4) : 16'(p);
      per_s <= rs ? 16'(p) : 16'(p + 6);
      apb(1'b1, 12'h000, {25'h0, fs, 2'b00, rs});
      apb(1'b0, 12'h000, {25'h0, fs, 2'b00, rs});
      for (b = 0; b < 4; b++)
        measure(b, p * ratio(b, fs[b]));
    end
    $display("bypass test done");
    per_d <= 16'h0060;
    fb_bank <= 2'h1;
    for (i = 0; i < 2; i++)
    begin
      fs = 4'($random(seed));
      m  = fs[1] ? 8 : 4;
      apb(1'b1, 12'h000, {22'h0, 2'h1, 1'b0, fs, 3'b010});
      repeat (1200) @(posedge ref_clk_in);
      for (b = 0; b < 4; b++)
        measure(b, 96 * ratio(b, fs[b]) / m);
      apb(1'b0, 12'h004, 32'h0060_0005);
      post(32'h1, {31'h0, lock_out});
      apb(1'b1, 12'h000, {22'h0, 2'h1, 1'b0, fs, 3'b110});
      repeat (200) @(posedge ref_clk_in);
      apb(1'b0, 12'h004, 32'h0060_000C);
      post(32'h0, {31'h0, lock_out});
      apb(1'b1, 12'h000, {22'h0, 2'h1, 1'b0, fs, 3'b010});
      repeat (1200) @(posedge ref_clk_in);
      apb(1'b0, 12'h004, 32'h0060_0005);
    end
    $display("loop test done");
    close_out;
  end
endmodule // testbench
